// ---- hdl/tco_pkg.sv ----
// Constants shared by the compare-output control block.
// Assumes one 250 MHz clock and an 8-bit register port.
package tco_pkg;
    // =====================================================
    // Register map
    localparam logic [7:0] TCO_ADDR_CTRL_A = 8'h19;
    localparam logic [7:0] TCO_ADDR_CTRL_B = 8'h18;
    localparam logic [7:0] TCO_ADDR_CNT = 8'h20;
    localparam logic [7:0] TCO_ADDR_CMP_A = 8'h21;
    localparam logic [7:0] TCO_ADDR_CMP_B = 8'h22;
    localparam logic [7:0] TCO_ADDR_STAT = 8'h23;
    localparam logic [7:0] TCO_ADDR_MASK = 8'h24;
    localparam logic [7:0] TCO_ADDR_TICKDIV = 8'h25;
    // =====================================================
    // Field layout and reset values
    localparam int TCO_MODE_A_HI = 7;
    localparam int TCO_MODE_A_LO = 6;
    localparam int TCO_MODE_B_HI = 5;
    localparam int TCO_MODE_B_LO = 4;
    localparam int TCO_WAVE_HI_BIT = 3;
    localparam logic [7:0] TCO_CTRL_A_WMASK = 8'hf3;
    localparam logic [7:0] TCO_CTRL_B_WMASK = 8'h08;
    localparam logic [7:0] TCO_RESET_VAL = 8'h00;
    localparam logic [7:0] TCO_MAX = 8'hff;
    localparam logic [7:0] TCO_BOTTOM = 8'h00;
    localparam int TCO_FLAG_A = 0;
    localparam int TCO_FLAG_B = 1;
    localparam logic [7:0] TCO_TICKDIV_RESET = 8'h00;
    // =====================================================
    // Waveform modes
    typedef enum logic [2:0] {
        TCO_WM_NORMAL = 3'b000,
        TCO_WM_PC_FF = 3'b001,
        TCO_WM_CTC = 3'b010,
        TCO_WM_FAST_FF = 3'b011,
        TCO_WM_RES4 = 3'b100,
        TCO_WM_PC_A = 3'b101,
        TCO_WM_RES6 = 3'b110,
        TCO_WM_FAST_A = 3'b111
    } tco_wave_t;
    typedef enum logic [1:0] {
        TCO_KIND_NONPWM = 2'b00,
        TCO_KIND_FAST = 2'b01,
        TCO_KIND_PHASE = 2'b10
    } tco_kind_t;
endpackage

// ---- hdl/tco_tick_div.sv ----
// Timer tick enable generator.
// Assumes one clock; the tick is a one-cycle enable, never a clock.
`timescale 1ns/1ps
module tco_tick_div
    import tco_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] div,
    output logic tick
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    wire wrap = (cnt_r >= div);

    assign cnt_nxt = wrap ? 8'h00 : 8'(cnt_r + 8'h01);
    // A divide value of zero gives a tick every cycle.
    assign tick = wrap;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ---- hdl/tco_out_unit.sv ----
// One compare output channel: decides the next output level.
// Assumes match, bottom and top strobes are already qualified by the tick.
`timescale 1ns/1ps
module tco_out_unit
    import tco_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] out_mode,
    input wire tco_kind_t kind,
    input wire logic toggle_ok,
    input wire logic match,
    input wire logic at_bottom,
    input wire logic at_top,
    input wire logic counting_up,
    input wire logic cmp_is_top,
    output logic level,
    output logic connected
);
    logic level_r;
    logic level_nxt;
    wire ignore_match = cmp_is_top & out_mode[1] & (kind != TCO_KIND_NONPWM);
    wire eff_match = match & ~ignore_match;
    wire inv = out_mode[0];

    assign connected = (out_mode != 2'b00) && !(kind != TCO_KIND_NONPWM && out_mode == 2'b01 && !toggle_ok);
    assign level = level_r;

    always_comb begin
        level_nxt = level_r;
        case (kind)
            TCO_KIND_NONPWM: begin
                if (match) begin
                    case (out_mode)
                        2'b01: level_nxt = ~level_r;
                        2'b10: level_nxt = 1'b0;
                        2'b11: level_nxt = 1'b1;
                        default: level_nxt = level_r;
                    endcase
                end
            end
            TCO_KIND_FAST: begin
                if (out_mode == 2'b01) begin
                    if (match && toggle_ok) begin
                        level_nxt = ~level_r;
                    end
                end else if (out_mode[1]) begin
                    if (eff_match) begin
                        level_nxt = inv;
                    end else if (at_bottom) begin
                        level_nxt = ~inv;
                    end
                end
            end
            TCO_KIND_PHASE: begin
                if (out_mode == 2'b01) begin
                    if (match && toggle_ok) begin
                        level_nxt = ~level_r;
                    end
                end else if (out_mode[1]) begin
                    // At TOP the level takes the down-counting action, so a compare value at TOP holds it steady.
                    if (ignore_match && at_top) begin
                        level_nxt = ~inv;
                    end else if (eff_match) begin
                        level_nxt = counting_up ? inv : ~inv;
                    end
                end
            end
            default: level_nxt = level_r;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            level_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
        end
    end
endmodule

// ---- hdl/tco_timer.sv ----
// 8-bit timer with two compare output channels and its register port.
// Assumes a synchronous host port with read data one cycle after the strobe.
//
// Overview of operation
// - Everything runs on ref_clk; timer tick is only a clock enable.
// - Flag B sets on every B match; flag A except in phase correct with A as TOP.
// - CLEAR_ON_MATCH_MODE and fast PWM with A as TOP: A match clears counter, sets flag.
// - Nonzero out mode A hands the A pin to the compare output.
// - Non-PWM mode A: 00 off, 01 toggle, 10 clear, 11 set on match.
// - PWM mode A 01: off if wave high bit clear, else toggle on match.
// - Fast PWM A: 10 clears on match, sets at bottom; 11 inverts this.
// - Fast PWM: compare equals TOP with upper bit set ignores match.
// - Phase correct A: 10 clears upward match, sets downward; 11 reversed.
// - Phase correct: compare equals TOP with upper bit acts at TOP.
// - Nonzero out mode B hands the B pin to the compare output.
// - Non-PWM mode B: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM B: 10 clear/bottom set, 11 inverse; 01 reserved.
// - Phase correct B: 10 clears upward match, sets downward; 11 reversed.
// - Control A bits 3:2 are reserved and read as zero.
// - Three wave mode bits select normal, PC, CLEAR_ON_MATCH_MODE, fast; 4 and 6 reserved.
`timescale 1ns/1ps
module tco_timer
    import tco_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [7:0] port_data_a,
    input wire logic [7:0] port_data_b,
    output logic pin_a,
    output logic pin_b,
    output logic pin_sel_a,
    output logic pin_sel_b,
    output logic irq
);
    // =====================================================
    // Registers
    logic [7:0] ctrl_a_r;
    logic [7:0] ctrl_b_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] cmp_a_r;
    logic [7:0] cmp_b_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic [7:0] tickdiv_r;
    logic [7:0] rdata_r;
    logic up_r;
    logic up_nxt;
    logic tick;
    logic oc_a;
    logic oc_b;
    logic conn_a;
    logic conn_b;
    logic block_r;
    tco_wave_t wave;
    tco_kind_t kind;
    logic [7:0] top;

    wire [1:0] out_mode_a = ctrl_a_r[TCO_MODE_A_HI:TCO_MODE_A_LO];
    wire [1:0] out_mode_b = ctrl_a_r[TCO_MODE_B_HI:TCO_MODE_B_LO];
    wire wave_mode_hi = ctrl_b_r[TCO_WAVE_HI_BIT];
    wire wr_ctrl_a = wr && (addr == TCO_ADDR_CTRL_A);
    wire wr_ctrl_b = wr && (addr == TCO_ADDR_CTRL_B);
    wire wr_cnt = wr && (addr == TCO_ADDR_CNT);
    wire wr_cmp_a = wr && (addr == TCO_ADDR_CMP_A);
    wire wr_cmp_b = wr && (addr == TCO_ADDR_CMP_B);
    wire wr_stat = wr && (addr == TCO_ADDR_STAT);
    wire wr_mask = wr && (addr == TCO_ADDR_MASK);
    wire wr_tickdiv = wr && (addr == TCO_ADDR_TICKDIV);

    // =====================================================
    // Mode decode
    assign wave = tco_wave_t'({wave_mode_hi, ctrl_a_r[1:0]});
    always_comb begin
        kind = TCO_KIND_NONPWM;
        top = TCO_MAX;
        case (wave)
            TCO_WM_NORMAL: begin
                kind = TCO_KIND_NONPWM;
            end
            TCO_WM_PC_FF: begin
                kind = TCO_KIND_PHASE;
            end
            TCO_WM_CTC: begin
                kind = TCO_KIND_NONPWM;
                top = cmp_a_r;
            end
            TCO_WM_FAST_FF: begin
                kind = TCO_KIND_FAST;
            end
            TCO_WM_PC_A: begin
                kind = TCO_KIND_PHASE;
                top = cmp_a_r;
            end
            TCO_WM_FAST_A: begin
                kind = TCO_KIND_FAST;
                top = cmp_a_r;
            end
            default: begin
                // Reserved codes behave as normal mode.
                kind = TCO_KIND_NONPWM;
            end
        endcase
    end
    wire a_is_top = (wave == TCO_WM_CTC) || (wave == TCO_WM_PC_A) || (wave == TCO_WM_FAST_A);

    // =====================================================
    // Counter and compare strobes
    tco_tick_div u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .div(tickdiv_r),
        .tick(tick)
    );
    // A software write to the counter suppresses the compare on the first tick at or after the write.
    wire live = tick && !block_r && !wr_cnt;
    wire match_a = live && (cnt_r == cmp_a_r);
    wire match_b = live && (cnt_r == cmp_b_r);
    wire at_top = tick && (cnt_r == top);
    wire at_bottom = tick && (kind == TCO_KIND_FAST) && (cnt_r == top);
    wire ctc_clear = (wave == TCO_WM_CTC) || (wave == TCO_WM_FAST_A);

    always_comb begin
        cnt_nxt = cnt_r;
        up_nxt = up_r;
        if (wr_cnt) begin
            cnt_nxt = wdata;
        end else if (tick) begin
            if (kind == TCO_KIND_PHASE) begin
                if (up_r && cnt_r >= top) begin
                    up_nxt = 1'b0;
                    cnt_nxt = 8'(cnt_r - 8'h01);
                end else if (!up_r && cnt_r == TCO_BOTTOM) begin
                    up_nxt = 1'b1;
                    cnt_nxt = 8'(cnt_r + 8'h01);
                end else begin
                    cnt_nxt = up_r ? 8'(cnt_r + 8'h01) : 8'(cnt_r - 8'h01);
                end
            end else if (ctc_clear && cnt_r == cmp_a_r) begin
                cnt_nxt = TCO_BOTTOM;
            end else begin
                up_nxt = 1'b1;
                cnt_nxt = (cnt_r == top) ? TCO_BOTTOM : 8'(cnt_r + 8'h01);
            end
        end
    end

    // =====================================================
    // Output channels
    tco_out_unit u_out_a (
        .ref_clk(ref_clk),
        .rst(rst),
        .out_mode(out_mode_a),
        .kind(kind),
        .toggle_ok(wave_mode_hi),
        .match(match_a),
        .at_bottom(at_bottom),
        .at_top(at_top),
        .counting_up(up_r),
        .cmp_is_top(cmp_a_r == top),
        .level(oc_a),
        .connected(conn_a)
    );
    tco_out_unit u_out_b (
        .ref_clk(ref_clk),
        .rst(rst),
        .out_mode(out_mode_b),
        .kind(kind),
        .toggle_ok(1'b0),
        .match(match_b),
        .at_bottom(at_bottom),
        .at_top(at_top),
        .counting_up(up_r),
        .cmp_is_top(cmp_b_r == top),
        .level(oc_b),
        .connected(conn_b)
    );

    // Pin direction is owned by the port logic outside; it must be set to output.
    assign pin_sel_a = (out_mode_a != 2'b00);
    assign pin_sel_b = (out_mode_b != 2'b00);
    assign pin_a = conn_a ? oc_a : (pin_sel_a ? 1'b0 : port_data_a[0]);
    assign pin_b = conn_b ? oc_b : (pin_sel_b ? 1'b0 : port_data_b[0]);

    // =====================================================
    // Flags and interrupt
    logic [1:0] set_ev;
    assign set_ev[TCO_FLAG_A] = match_a && !(a_is_top && !ctc_clear);
    assign set_ev[TCO_FLAG_B] = match_b;
    wire [1:0] clr_ev = wr_stat ? wdata[1:0] : 2'b00;
    assign irq = |(stat_r & mask_r);

    // =====================================================
    // Read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (addr)
            TCO_ADDR_CTRL_A: rd_mux = ctrl_a_r;
            TCO_ADDR_CTRL_B: rd_mux = ctrl_b_r;
            TCO_ADDR_CNT: rd_mux = cnt_r;
            TCO_ADDR_CMP_A: rd_mux = cmp_a_r;
            TCO_ADDR_CMP_B: rd_mux = cmp_b_r;
            TCO_ADDR_STAT: rd_mux = {6'h00, stat_r};
            TCO_ADDR_MASK: rd_mux = {6'h00, mask_r};
            TCO_ADDR_TICKDIV: rd_mux = tickdiv_r;
            default: rd_mux = 8'h00;
        endcase
    end
    assign rdata = rdata_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_a_r <= TCO_RESET_VAL;
            ctrl_b_r <= TCO_RESET_VAL;
            cnt_r <= TCO_RESET_VAL;
            cmp_a_r <= TCO_RESET_VAL;
            cmp_b_r <= TCO_RESET_VAL;
            stat_r <= 2'b00;
            mask_r <= 2'b00;
            tickdiv_r <= TCO_TICKDIV_RESET;
            rdata_r <= 8'h00;
            up_r <= 1'b1;
            block_r <= 1'b0;
        end else begin
            if (wr_ctrl_a) ctrl_a_r <= wdata & TCO_CTRL_A_WMASK;
            if (wr_ctrl_b) ctrl_b_r <= wdata & TCO_CTRL_B_WMASK;
            if (wr_cmp_a) cmp_a_r <= wdata;
            if (wr_cmp_b) cmp_b_r <= wdata;
            if (wr_mask) mask_r <= wdata[1:0];
            if (wr_tickdiv) tickdiv_r <= wdata;
            cnt_r <= cnt_nxt;
            up_r <= up_nxt;
            block_r <= wr_cnt ? !tick : (block_r && !tick);
            stat_r <= (stat_r & ~clr_ev) | set_ev;
            rdata_r <= rd ? rd_mux : 8'h00;
        end
    end

    // =====================================================
    // Checks
    sequence s_b_match;
        match_b;
    endsequence
    a_flag_b_set: assert property (@(posedge ref_clk) disable iff (rst) s_b_match |=> stat_r[TCO_FLAG_B])
        else $error("flag B not set after match");
    a_ctc_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && !wr_cnt && ctc_clear && cnt_r == cmp_a_r) |=> cnt_r == TCO_BOTTOM)
        else $error("counter not cleared on compare A");
    a_pin_sel_a: assert property (@(posedge ref_clk) disable iff (rst) pin_sel_a == (|ctrl_a_r[7:6]))
        else $error("pin A select wrong");
    a_pin_sel_b: assert property (@(posedge ref_clk) disable iff (rst) pin_sel_b == (|ctrl_a_r[5:4]))
        else $error("pin B select wrong");
    a_np_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (kind == TCO_KIND_NONPWM && out_mode_a == 2'b10 && match_a) |=> !oc_a)
        else $error("output A not cleared");
    a_np_set_b: assert property (@(posedge ref_clk) disable iff (rst)
        (kind == TCO_KIND_NONPWM && out_mode_b == 2'b11 && match_b) |=> oc_b)
        else $error("output B not set");
    a_pwm_toggle_off: assert property (@(posedge ref_clk) disable iff (rst)
        (kind != TCO_KIND_NONPWM && out_mode_a == 2'b01 && !wave_mode_hi) |-> !conn_a && !pin_a)
        else $error("reserved toggle drives pin");
    a_fast_bottom_b: assert property (@(posedge ref_clk) disable iff (rst)
        (kind == TCO_KIND_FAST && out_mode_b == 2'b10 && at_bottom && !match_b) |=> oc_b)
        else $error("output B not set at bottom");
    a_pc_up_b: assert property (@(posedge ref_clk) disable iff (rst)
        (kind == TCO_KIND_PHASE && out_mode_b == 2'b10 && match_b && up_r && cmp_b_r != top) |=> !oc_b)
        else $error("output B not cleared on up match");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst) ctrl_a_r[3:2] == 2'b00)
        else $error("reserved bits nonzero");
    sequence s_pc_top_a;
        kind == TCO_KIND_PHASE && out_mode_a == 2'b10 && cmp_a_r == top && at_top;
    endsequence
    a_fast_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (kind == TCO_KIND_FAST && out_mode_a == 2'b10 && match_a && cmp_a_r != top) |=> !oc_a)
        else $error("output A not cleared on fast match");
    a_fast_bottom_a: assert property (@(posedge ref_clk) disable iff (rst)
        (kind == TCO_KIND_FAST && out_mode_a == 2'b11 && at_bottom) |=> !oc_a)
        else $error("output A not cleared at bottom");
    a_fast_set_b: assert property (@(posedge ref_clk) disable iff (rst)
        (kind == TCO_KIND_FAST && out_mode_b == 2'b11 && match_b && cmp_b_r != top) |=> oc_b)
        else $error("output B not set on fast match");
    a_fast_ignore_b: assert property (@(posedge ref_clk) disable iff (rst)
        (kind == TCO_KIND_FAST && out_mode_b == 2'b10 && cmp_b_r == top && oc_b) |=> oc_b)
        else $error("output B cleared by an ignored match");
    a_pc_down_a: assert property (@(posedge ref_clk) disable iff (rst)
        (kind == TCO_KIND_PHASE && out_mode_a == 2'b10 && match_a && !up_r && cmp_a_r != top) |=> oc_a)
        else $error("output A not set on down match");
    a_pc_top_a: assert property (@(posedge ref_clk) disable iff (rst) s_pc_top_a |=> oc_a)
        else $error("output A not set at top");
    a_flag_a_top: assert property (@(posedge ref_clk) disable iff (rst)
        (wave == TCO_WM_PC_A && !stat_r[TCO_FLAG_A]) |=> !stat_r[TCO_FLAG_A])
        else $error("flag A set while A is top");
    a_ctc_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ctc_clear && match_a) |=> stat_r[TCO_FLAG_A])
        else $error("flag A not set on clearing match");
endmodule

// ---- test/tb_timer_compare_output_control.sv ----
// Self-checking bench for the compare-output timer block.
// Assumes the tco_pkg register map and a tick divider left at zero (tick every cycle).
`timescale 1ns/1ps
module tb_timer_compare_output_control;
    import tco_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] port_data_a = 8'h01;
    logic [7:0] port_data_b = 8'h01;
    logic pin_a, pin_b, pin_sel_a, pin_sel_b, irq;
    int errors = 0;
    int n_tests = 0;
    int ha, hb;
    logic [7:0] v;

    tco_timer dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .port_data_a(port_data_a), .port_data_b(port_data_b), .pin_a(pin_a), .pin_b(pin_b),
        .pin_sel_a(pin_sel_a), .pin_sel_b(pin_sel_b), .irq(irq));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // =====================================================
    // Bus and comparison helpers
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken at that cycle's falling edge.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask

    task automatic count_high(input int n);
        ha = 0;
        hb = 0;
        repeat (n) begin
            @(negedge ref_clk);
            ha += int'(pin_a);
            hb += int'(pin_b);
        end
    endtask

    function automatic logic [15:0] near(input int x, input int e, input int tol);
        return {15'h0000, (x >= e - tol) && (x <= e + tol)};
    endfunction

    // A full counter period is at most 510 ticks, so 700 polls always cover one match.
    task automatic wait_flag(input int b);
        int k;
        k = 0;
        v = 8'h00;
        while (v[b] !== 1'b1 && k < 700) begin
            rd_reg(TCO_ADDR_STAT, v);
            k++;
        end
        check("flag_wait", {15'h0000, v[b]}, 16'h0001);
        repeat (3) @(posedge ref_clk);
    endtask

    // =====================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] adrs [9];
        logic [7:0] expv [9];
        adrs = '{TCO_ADDR_CTRL_A, TCO_ADDR_CTRL_B, TCO_ADDR_CNT, TCO_ADDR_CMP_A, TCO_ADDR_CMP_B,
            TCO_ADDR_STAT, TCO_ADDR_MASK, TCO_ADDR_TICKDIV, 8'h00};
        // The counter has run five ticks when it is sampled, and both compares matched zero at the first tick.
        expv = '{TCO_RESET_VAL, TCO_RESET_VAL, 8'h05, TCO_RESET_VAL, TCO_RESET_VAL, 8'h03, TCO_RESET_VAL,
            TCO_TICKDIV_RESET, 8'h00};
        check("pins_idle", {12'h000, pin_a, pin_b, pin_sel_a, pin_sel_b}, 16'h000c);
        check("irq_idle", {15'h0000, irq}, 16'h0000);
        foreach (adrs[i]) begin
            rd_reg(adrs[i], v);
            check("reset_value", {8'h00, v}, {8'h00, expv[i]});
        end
    endtask

    task automatic t_regs();
        wr_reg(TCO_ADDR_CTRL_A, 8'hff);
        rd_reg(TCO_ADDR_CTRL_A, v);
        check("ctrl_a_mask", {8'h00, v}, 16'h00f3);
        check("sel_a_on", {15'h0000, pin_sel_a}, 16'h0001);
        check("sel_b_on", {15'h0000, pin_sel_b}, 16'h0001);
        wr_reg(TCO_ADDR_CTRL_B, 8'hff);
        rd_reg(TCO_ADDR_CTRL_B, v);
        check("ctrl_b_mask", {8'h00, v}, 16'h0008);
        wr_reg(8'h30, 8'h5a);
        rd_reg(8'h30, v);
        check("unmapped", {8'h00, v}, 16'h0000);
        wr_reg(TCO_ADDR_CTRL_B, 8'h00);
        wr_reg(TCO_ADDR_CTRL_A, 8'h00);
        @(negedge ref_clk);
        check("port_back", {14'h0000, pin_a, pin_sel_a}, 16'h0002);
    endtask

    // Set, clear, toggle, toggle: each step must move the level, so a stuck output is caught.
    task automatic t_nonpwm();
        logic [1:0] modes [4];
        logic lv [4];
        modes = '{2'b11, 2'b10, 2'b01, 2'b01};
        lv = '{1'b1, 1'b0, 1'b1, 1'b0};
        wr_reg(TCO_ADDR_CMP_A, 8'h10);
        wr_reg(TCO_ADDR_CMP_B, 8'h30);
        wr_reg(TCO_ADDR_MASK, 8'h03);
        foreach (modes[i]) begin
            // Restarting the counter keeps exactly one match of each channel inside every step.
            wr_reg(TCO_ADDR_CNT, 8'h00);
            wr_reg(TCO_ADDR_CTRL_A, {modes[i], modes[i], 4'h0});
            wr_reg(TCO_ADDR_STAT, 8'h03);
            wait_flag(TCO_FLAG_A);
            wait_flag(TCO_FLAG_B);
            check("nonpwm_a", {15'h0000, pin_a}, {15'h0000, lv[i]});
            check("nonpwm_b", {15'h0000, pin_b}, {15'h0000, lv[i]});
            check("irq_set", {15'h0000, irq}, 16'h0001);
        end
        wr_reg(TCO_ADDR_STAT, 8'h03);
        @(negedge ref_clk);
        check("irq_clear", {15'h0000, irq}, 16'h0000);
    endtask

    task automatic t_ctc();
        logic [7:0] mx;
        mx = 8'h00;
        wr_reg(TCO_ADDR_CMP_A, 8'h20);
        wr_reg(TCO_ADDR_CTRL_A, 8'h02);
        wr_reg(TCO_ADDR_STAT, 8'h03);
        wait_flag(TCO_FLAG_A);
        repeat (60) begin
            rd_reg(TCO_ADDR_CNT, v);
            if (v > mx) mx = v;
        end
        check("ctc_wrap", {15'h0000, mx <= 8'h20}, 16'h0001);
    endtask

    task automatic t_fast();
        wr_reg(TCO_ADDR_CMP_A, 8'h80);
        wr_reg(TCO_ADDR_CMP_B, 8'h40);
        wr_reg(TCO_ADDR_CTRL_A, 8'hb3);
        repeat (300) @(posedge ref_clk);
        count_high(512);
        check("fast_a_duty", near(ha, 258, 4), 16'h0001);
        check("fast_b_duty", near(hb, 382, 4), 16'h0001);
        wr_reg(TCO_ADDR_CMP_A, 8'hff);
        wr_reg(TCO_ADDR_CMP_B, 8'hff);
        wr_reg(TCO_ADDR_CTRL_A, 8'ha3);
        repeat (300) @(posedge ref_clk);
        count_high(512);
        check("fast_top_a", 16'(ha), 16'h0200);
        check("fast_top_b", 16'(hb), 16'h0200);
    endtask

    task automatic t_phase();
        wr_reg(TCO_ADDR_CMP_A, 8'h80);
        wr_reg(TCO_ADDR_CMP_B, 8'h40);
        wr_reg(TCO_ADDR_CTRL_A, 8'hb1);
        repeat (600) @(posedge ref_clk);
        count_high(1020);
        check("phase_a_duty", near(ha, 512, 8), 16'h0001);
        check("phase_b_duty", near(hb, 764, 8), 16'h0001);
        wr_reg(TCO_ADDR_CMP_A, 8'hff);
        wr_reg(TCO_ADDR_CTRL_A, 8'h81);
        repeat (600) @(posedge ref_clk);
        count_high(1020);
        check("phase_top_a", 16'(ha), 16'h03fc);
    endtask

    task automatic t_toggle();
        wr_reg(TCO_ADDR_CTRL_A, 8'h43);
        repeat (4) @(posedge ref_clk);
        count_high(300);
        check("pwm_01_off", {pin_sel_a, 15'(ha)}, 16'h8000);
        wr_reg(TCO_ADDR_CMP_A, 8'h3f);
        wr_reg(TCO_ADDR_CTRL_B, 8'h08);
        repeat (300) @(posedge ref_clk);
        count_high(512);
        check("pwm_01_toggle", near(ha, 256, 4), 16'h0001);
        wr_reg(TCO_ADDR_STAT, 8'h03);
        wait_flag(TCO_FLAG_A);
        rd_reg(TCO_ADDR_CNT, v);
        check("fast_a_top", {15'h0000, v <= 8'h3f}, 16'h0001);
    endtask

    // With A as TOP in phase correct mode only flag B may rise; the mask then selects the irq source.
    task automatic t_flags_pc();
        wr_reg(TCO_ADDR_CMP_A, 8'h80);
        wr_reg(TCO_ADDR_CMP_B, 8'h10);
        wr_reg(TCO_ADDR_CTRL_A, 8'h01);
        wr_reg(TCO_ADDR_STAT, 8'h03);
        repeat (600) @(posedge ref_clk);
        rd_reg(TCO_ADDR_STAT, v);
        check("pc_flags", {8'h00, v}, 16'h0002);
        check("irq_b", {15'h0000, irq}, 16'h0001);
        wr_reg(TCO_ADDR_MASK, 8'h01);
        @(negedge ref_clk);
        check("irq_masked", {15'h0000, irq}, 16'h0000);
    endtask

    // =====================================================
    // Run control
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        t_reset();
        t_regs();
        t_nonpwm();
        t_ctc();
        t_fast();
        t_phase();
        t_toggle();
        t_flags_pc();
        end_of_test();
    end

    // The whole sequence needs roughly 7300 cycles; a limit of 50000 cycles leaves ample margin.
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
endmodule
